// ===== hub_lpc_pkg.sv
// hub_lpc_pkg: shared constants for the hub-write / lpc-read bus ends
// assumes one bus clock shared by both ends
package hub_lpc_pkg;
  localparam logic [3:0] HUB_WRITE_START = 4'hE;
  localparam logic [3:0] LPC_START = 4'h0;
  localparam logic [3:0] LPC_READ_TYPE = 4'h4;
  localparam logic [1:0] LPC_TYPE_HI = 2'h1;
  localparam logic [3:0] SIZE_ONE = 4'h0;
  localparam logic [3:0] SIZE_TWO = 4'h1;
  localparam logic [3:0] SIZE_FOUR = 4'h2;
  localparam logic [3:0] NIB_TAR = 4'hF;
  localparam logic [3:0] NIB_SYNC_OK = 4'h0;
  localparam logic [3:0] NIB_WAIT_SYNC = 4'h5;
  localparam int HUB_ADDR_NIBBLES = 7;
  localparam int LPC_ADDR_NIBBLES = 8;
  localparam int WAIT_SYNC_CLOCKS = 2;
  localparam int MEM_SEL_BIT = 22;
  localparam logic [8:0] LPC_ADDR_TOP_ONES = 9'h1FF;
  localparam logic [3:0] CHIP_SELECT_ID_RESET = 4'h0;
endpackage : hub_lpc_pkg

// ===== hub_lpc_if.sv
// hub_lpc_if: nibble bus and frame strobe between host and device
// assumes one end enabled at a time; the shared nibble lines are resolved here from the enables
`timescale 1ns/1ns
interface hub_lpc_if;
  logic hub_frame_strobe_n;
  logic [3:0] host_nib_out;
  logic host_nib_oe;
  logic [3:0] dev_nib_out;
  logic dev_nib_oe;
  logic [3:0] hub_nibble_lines;
  // pulled-up bus: floats to all ones
  assign hub_nibble_lines = host_nib_oe ? host_nib_out :
                            dev_nib_oe ? dev_nib_out : 4'hF;
  modport device (
    input hub_frame_strobe_n,
    input hub_nibble_lines,
    output dev_nib_out,
    output dev_nib_oe
  );
  modport host (
    output hub_frame_strobe_n,
    output host_nib_out,
    output host_nib_oe,
    input hub_nibble_lines
  );
endinterface : hub_lpc_if

// ===== hub_lpc_device.sv
// hub_lpc_device: flash-side cycle logic, hub write and lpc byte read
// assumes host keeps its own turnaround; reads served from read_data input
// Function
// R1 - hub write starts on 1110b, frame low
// R2 - clock two select nibble matched to strap
// R3 - 28-bit address, seven nibbles, msn first
// R4 - a22 set memory, else register decode
// R5 - size code 0000 one, 0001 two, 0010 four
// R6 - data two clocks per byte, low first
// R7 - multi-byte writes step low address bits
// R8 - host drives 1111b turnaround after data
// R9 - device owns lines next clock, floating
// R10 - device drives 0000b acknowledge sync
// R11 - then 1111b, then release lines
// R12 - lpc cycle starts on 0000b, frame low
// R13 - read type 01,0,x in clock two
// R14 - 32-bit address, eight nibbles, top ones
// R15 - lpc a22 set memory, clear register
// R16 - host drives 1111b turnaround after address
// R17 - clock 12 device owns floating lines; code drives 1111b there
// R18 - two wait syncs 0101b, clocks 13-14
// R19 - ready sync 0000b at clock 15
// R20 - data clocks 16-17, low nibble first
// R21 - 1111b at clock 18, float at 19
// R22 - mismatch or unknown start: stay off bus
// R23 - everything on rising clock edges
`timescale 1ns/1ns
module hub_lpc_device
  import hub_lpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  hub_lpc_if.device bus,
  input wire logic [3:0] chip_select_id,
  input wire logic [7:0] read_data,
  output logic wr_valid,
  output logic [27:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wr_mem,
  output logic rd_req,
  output logic [31:0] rd_addr,
  output logic rd_mem
);
  import hub_lpc_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_HSEL = 4'h1, S_HADDR = 4'h3, S_HSIZE = 4'h2,
    S_HDATA = 4'h6, S_HTAR = 4'h7, S_TAKE = 4'h5, S_ACK = 4'h4,
    S_LTYPE = 4'hC, S_LADDR = 4'hD, S_LTAR = 4'hF, S_WAIT = 4'hE,
    S_RDY = 4'hA, S_RDAT = 4'hB, S_TEND = 4'h9, S_FLOAT = 4'h8
  } state_t;

  state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [31:0] addr_q, addr_d;
  logic [3:0] size_q, size_d;
  logic [3:0] lo_q, lo_d;
  logic [7:0] rbyte_q, rbyte_d;
  logic [3:0] nib_q, nib_d;
  logic oe_q, oe_d;
  logic wv_q, wv_d;
  logic [7:0] wd_q, wd_d;
  logic [27:0] wa_q, wa_d;
  logic rq_q, rq_d;
  logic [3:0] nib;
  logic frame;
  logic [3:0] last_cnt;

  assign nib = bus.hub_nibble_lines;
  assign frame = !bus.hub_frame_strobe_n;
  assign bus.dev_nib_out = nib_q;
  assign bus.dev_nib_oe = oe_q;
  assign wr_valid = wv_q;
  assign wr_data = wd_q;
  assign wr_addr = wa_q;
  // array writes ignore a20-21 and a23-27 by masking them out
  assign wr_mem = wa_q[MEM_SEL_BIT]; // R4
  assign rd_req = rq_q;
  assign rd_addr = addr_q;
  assign rd_mem = addr_q[MEM_SEL_BIT]; // R15
  // data nibbles minus one: 2/4/8 clocks
  assign last_cnt = (size_q == SIZE_FOUR) ? 4'h7 :
                    (size_q == SIZE_TWO) ? 4'h3 : 4'h1; // R6

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 4'h1; // R23
    addr_d = addr_q;
    size_d = size_q;
    lo_d = lo_q;
    rbyte_d = rbyte_q;
    nib_d = NIB_TAR;
    oe_d = 1'b0;
    wv_d = 1'b0;
    wd_d = wd_q;
    wa_d = wa_q;
    rq_d = 1'b0;
    unique case (st_q)
      S_IDLE: begin
        cnt_d = 4'h0;
        if (frame && nib == HUB_WRITE_START) st_d = S_HSEL; // R1
        else if (frame && nib == LPC_START) st_d = S_LTYPE; // R12
      end
      S_HSEL: begin
        cnt_d = 4'h0;
        addr_d = 32'h0;
        if (nib == chip_select_id) st_d = S_HADDR; // R2
        else st_d = S_IDLE; // R22
      end
      S_HADDR: begin
        addr_d = {addr_q[27:0], nib}; // R3
        if (cnt_q == 4'(HUB_ADDR_NIBBLES - 1)) st_d = S_HSIZE;
      end
      S_HSIZE: begin
        size_d = nib; // R5
        cnt_d = 4'h0;
        if (nib == SIZE_ONE || nib == SIZE_TWO || nib == SIZE_FOUR)
          st_d = S_HDATA;
        else st_d = S_IDLE; // R22
      end
      S_HDATA: begin
        if (!cnt_q[0]) begin
          lo_d = nib; // R6
        end else begin
          wv_d = 1'b1;
          wd_d = {nib, lo_q}; // R6
          wa_d = addr_q[27:0]; // R4
          if (addr_q[MEM_SEL_BIT]) begin
            wa_d[21:20] = 2'h0; // R4
            wa_d[27:23] = 5'h0; // R4
          end
          if (size_q == SIZE_FOUR) wa_d[1:0] = cnt_q[2:1]; // R7
          else if (size_q == SIZE_TWO) wa_d[0] = cnt_q[1]; // R7
        end
        if (cnt_q == last_cnt) st_d = S_HTAR;
      end
      S_HTAR: st_d = S_TAKE; // R8
      S_TAKE: begin
        // lines float this clock while we take them
        oe_d = 1'b1; // R9
        nib_d = NIB_SYNC_OK; // R10
        st_d = S_ACK;
      end
      S_ACK: begin
        oe_d = 1'b1;
        nib_d = NIB_TAR; // R11
        st_d = S_FLOAT;
      end
      S_LTYPE: begin
        cnt_d = 4'h0;
        addr_d = 32'h0;
        if (nib[3:2] == LPC_TYPE_HI && !nib[1]) st_d = S_LADDR; // R13
        else st_d = S_IDLE; // R22
      end
      S_LADDR: begin
        addr_d = {addr_q[27:0], nib}; // R14
        if (cnt_q == 4'(LPC_ADDR_NIBBLES - 1)) begin
          st_d = S_LTAR;
          rq_d = 1'b1;
        end
      end
      S_LTAR: begin
        // clock 11: host turnaround; next clock we take the lines
        oe_d = 1'b1; // R16
        nib_d = NIB_TAR; // R17
        cnt_d = 4'h0;
        st_d = S_WAIT;
        rbyte_d = read_data;
      end
      S_WAIT: begin
        oe_d = 1'b1;
        nib_d = NIB_WAIT_SYNC; // R18
        if (cnt_q == 4'(WAIT_SYNC_CLOCKS - 1)) st_d = S_RDY;
      end
      S_RDY: begin
        oe_d = 1'b1;
        // ready sync at clock 15; data follows next clock
        nib_d = NIB_SYNC_OK; // R19
        st_d = S_RDAT;
        cnt_d = 4'h0;
      end
      S_RDAT: begin
        oe_d = 1'b1;
        // low nibble in clock 16, high nibble in clock 17
        nib_d = cnt_q[0] ? rbyte_q[7:4] : rbyte_q[3:0]; // R20
        if (cnt_q[0]) st_d = S_TEND;
      end
      S_TEND: begin
        oe_d = 1'b1;
        nib_d = NIB_TAR; // R21
        st_d = S_FLOAT;
      end
      S_FLOAT: st_d = S_IDLE; // R11 R21
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      addr_q <= 32'h0;
      size_q <= 4'h0;
      lo_q <= 4'h0;
      rbyte_q <= 8'h0;
      nib_q <= NIB_TAR;
      oe_q <= 1'b0;
      wv_q <= 1'b0;
      wd_q <= 8'h0;
      wa_q <= 28'h0;
      rq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      size_q <= size_d;
      lo_q <= lo_d;
      rbyte_q <= rbyte_d;
      nib_q <= nib_d;
      oe_q <= oe_d;
      wv_q <= wv_d;
      wd_q <= wd_d;
      wa_q <= wa_d;
      rq_q <= rq_d;
    end
  end
endmodule : hub_lpc_device

// ===== hub_lpc_host.sv
// hub_lpc_host: chipset-side initiator of hub writes and lpc byte reads
// assumes device answers with fixed sync timing; one request at a time
`timescale 1ns/1ns
module hub_lpc_host
  import hub_lpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  hub_lpc_if.host bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [3:0] req_id,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_size,
  input wire logic [31:0] req_wdata,
  output logic req_ready,
  output logic done,
  output logic ack_ok,
  output logic [7:0] rdata
);
  import hub_lpc_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_SEND = 3'h1, H_TAR = 3'h3, H_RESP = 3'h2
  } hstate_t;

  hstate_t st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [63:0] sh_q, sh_d;
  logic [5:0] len_q, len_d;
  logic wr_q, wr_d;
  logic frm_q, frm_d;
  logic done_q, done_d;
  logic ok_q, ok_d;
  logic [7:0] rd_q, rd_d;
  logic [3:0] rlo_q, rlo_d;
  logic [31:0] wdat_q, wdat_d;
  logic [5:0] nbytes;
  logic [63:0] wseq;
  logic [3:0] nib;

  assign nib = bus.hub_nibble_lines;
  assign bus.hub_frame_strobe_n = !frm_q;
  assign bus.host_nib_out = sh_q[63:60];
  assign bus.host_nib_oe = (st_q == H_SEND) || (st_q == H_TAR);
  assign req_ready = (st_q == H_IDLE);
  assign done = done_q;
  assign ack_ok = ok_q;
  assign rdata = rd_q;
  assign nbytes = (req_size == SIZE_FOUR) ? 6'd4 :
                  (req_size == SIZE_TWO) ? 6'd2 : 6'd1;

  // data bytes in address order, low nibble first
  always_comb begin
    wseq = 64'h0;
    for (int i = 0; i < 4; i++) begin
      wseq[63 - 8*i -: 4] = wdat_q[8*i +: 4]; // R6
      wseq[59 - 8*i -: 4] = wdat_q[8*i + 4 +: 4];
    end
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 6'h1;
    sh_d = sh_q;
    len_d = len_q;
    wr_d = wr_q;
    frm_d = 1'b0;
    done_d = 1'b0;
    ok_d = ok_q;
    rd_d = rd_q;
    rlo_d = rlo_q;
    wdat_d = wdat_q;
    unique case (st_q)
      H_IDLE: begin
        cnt_d = 6'h0;
        if (req_valid) begin
          st_d = H_SEND;
          frm_d = 1'b1;
          wr_d = req_write;
          ok_d = 1'b0;
          // held here: the requester may move on after accept
          wdat_d = req_wdata;
          if (req_write) begin
            // start, id, 7 address nibbles, size, then data
            sh_d = {HUB_WRITE_START, req_id, req_addr[27:0],
                    req_size, 24'h0}; // R1 R2 R3 R5
            len_d = 6'd10 + 6'(2 * nbytes);
          end else begin
            sh_d = {LPC_START, LPC_READ_TYPE, LPC_ADDR_TOP_ONES,
                    req_addr[22:0], 24'h0}; // R12 R13 R14
            len_d = 6'd10;
          end
        end
      end
      H_SEND: begin
        sh_d = {sh_q[59:0], 4'h0};
        if (wr_q && cnt_q == 6'd9) sh_d[63:0] = wseq;
        if (cnt_q == len_q - 6'h1) begin
          st_d = H_TAR;
          sh_d = {NIB_TAR, 60'h0}; // R8 R16
        end
      end
      H_TAR: begin
        st_d = H_RESP;
        cnt_d = 6'h0;
      end
      H_RESP: begin
        if (wr_q) begin
          // device: float, 0000b sync, 1111b, float
          if (cnt_q == 6'd1) ok_d = (nib == NIB_SYNC_OK); // R10
          if (cnt_q == 6'd3) begin
            st_d = H_IDLE;
            done_d = 1'b1;
          end
        end else begin
          if (cnt_q == 6'd3) ok_d = (nib == NIB_SYNC_OK); // R19
          if (cnt_q == 6'd4) rlo_d = nib; // R20
          if (cnt_q == 6'd5) rd_d = {nib, rlo_q};
          if (cnt_q == 6'd7) begin
            st_d = H_IDLE;
            done_d = 1'b1;
          end
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q <= H_IDLE;
      cnt_q <= 6'h0;
      sh_q <= 64'h0;
      len_q <= 6'h0;
      wr_q <= 1'b0;
      frm_q <= 1'b0;
      done_q <= 1'b0;
      ok_q <= 1'b0;
      rd_q <= 8'h0;
      rlo_q <= 4'h0;
      wdat_q <= 32'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      len_q <= len_d;
      wr_q <= wr_d;
      frm_q <= frm_d;
      done_q <= done_d;
      ok_q <= ok_d;
      rd_q <= rd_d;
      rlo_q <= rlo_d;
      wdat_q <= wdat_d;
    end
  end
endmodule : hub_lpc_host

// ===== hub_lpc_properties.sv
// hub_lpc_properties: wire timing of the device end of the bus
// assumes the device strap equals SELF_ID; sees interface nets only
`timescale 1ns/1ns
module hub_lpc_properties
  import hub_lpc_pkg::*;
#(
  parameter logic [3:0] SELF_ID = 4'h0
)(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hub_frame_strobe_n,
  input wire logic host_nib_oe,
  input wire logic dev_nib_oe,
  input wire logic [3:0] hub_nibble_lines
);
  logic [3:0] nb;
  logic fl;
  assign nb = hub_nibble_lines;
  assign fl = !hub_frame_strobe_n;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence hub_head(logic [3:0] sz);
    fl && nb == HUB_WRITE_START ##1 nb == SELF_ID ##8 nb == sz;
  endsequence
  // float clock kept apart: ack may not share the takeover clock
  sequence dev_ack;
    nb == NIB_TAR ##1 nb == NIB_TAR && !host_nib_oe
    ##1 dev_nib_oe && nb == NIB_SYNC_OK
    ##1 dev_nib_oe && nb == NIB_TAR ##1 !dev_nib_oe;
  endsequence
  sequence lpc_rd;
    fl && nb == LPC_START ##1 nb[3:1] == 3'h2;
  endsequence
  hub_one_ack_a: assert property (hub_head(SIZE_ONE) |-> ##3 dev_ack)
    else $error("single write ack out of place");
  hub_two_ack_a: assert property (hub_head(SIZE_TWO) |-> ##5 dev_ack)
    else $error("double write ack out of place");
  hub_four_ack_a: assert property (hub_head(SIZE_FOUR) |-> ##9 dev_ack)
    else $error("quad write ack out of place");
  hub_data_quiet_a: assert property (
    hub_head(SIZE_FOUR) |-> (!dev_nib_oe)[*8] ##1 !dev_nib_oe)
    else $error("device drove during write data");
  lpc_sync_order_a: assert property (lpc_rd |-> ##10
    dev_nib_oe && nb == NIB_TAR ##1 (dev_nib_oe && nb == NIB_WAIT_SYNC)[*2]
    ##1 dev_nib_oe && nb == NIB_SYNC_OK)
    else $error("read sync order wrong");
  lpc_tail_a: assert property (lpc_rd |-> ##16
    dev_nib_oe && nb == NIB_TAR ##1 !dev_nib_oe)
    else $error("read turnaround wrong");
  id_miss_quiet_a: assert property (
    fl && nb == HUB_WRITE_START ##1 nb != SELF_ID |->
    (!dev_nib_oe)[*8] ##1 (!dev_nib_oe)[*8] ##1 (!dev_nib_oe)[*8])
    else $error("unselected device drove the bus");
  no_clash_a: assert property (!(host_nib_oe && dev_nib_oe))
    else $error("both ends drive the bus");
endmodule : hub_lpc_properties

// ===== hub_write_lpc_read_cycles_tb.sv
// hub_write_lpc_read_cycles_tb: host and device ends joined by the bus
// assumes a tied strap; read bytes served from read_data
`timescale 1ns/1ns
module hub_write_lpc_read_cycles_tb;
  import hub_lpc_pkg::*;
  localparam logic [3:0] ID = 4'h3;
  logic sys_clk;
  logic reset;
  logic req_valid;
  logic req_write;
  logic [3:0] req_id;
  logic [31:0] req_addr;
  logic [3:0] req_size;
  logic [31:0] req_wdata;
  logic req_ready;
  logic done;
  logic ack_ok;
  logic [7:0] rdata;
  logic [7:0] read_data;
  logic wr_valid;
  logic [27:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_mem;
  logic rd_req;
  logic [31:0] rd_addr;
  logic rd_mem;
  logic [3:0] nb;
  logic [7:0] wb;
  int cyc;
  int error_cnt;
  int num_checks;
  logic [36:0] wq[$];
  logic [32:0] rq[$];
  // rows: write flag, size code, address, data
  logic [68:0] rows [6];
  hub_lpc_if i_hub_lpc_if();
  hub_lpc_device i_hub_lpc_device(.sys_clk, .reset,
    .bus(i_hub_lpc_if.device), .chip_select_id(ID), .read_data,
    .wr_valid, .wr_addr, .wr_data, .wr_mem, .rd_req, .rd_addr, .rd_mem);
  hub_lpc_host i_hub_lpc_host(.sys_clk, .reset, .bus(i_hub_lpc_if.host),
    .req_valid, .req_write, .req_id, .req_addr, .req_size, .req_wdata,
    .req_ready, .done, .ack_ok, .rdata);
  hub_lpc_properties #(.SELF_ID(ID)) i_hub_lpc_properties(.sys_clk,
    .reset, .hub_frame_strobe_n(i_hub_lpc_if.hub_frame_strobe_n),
    .host_nib_oe(i_hub_lpc_if.host_nib_oe),
    .dev_nib_oe(i_hub_lpc_if.dev_nib_oe), .hub_nibble_lines(nb));
  assign nb = i_hub_lpc_if.hub_nibble_lines;
  always #20 sys_clk = ~sys_clk;
  // count clocks from the frame strobe, take the read byte off the wire
  always @(posedge sys_clk) begin
    if (!i_hub_lpc_if.hub_frame_strobe_n) cyc = 1;
    else cyc++;
    if (cyc == 16) wb[3:0] = nb;
    if (cyc == 17) wb[7:4] = nb;
  end
  always @(negedge sys_clk) begin
    if (wr_valid === 1'h1) wq.push_back({wr_mem, wr_addr, wr_data});
    if (rd_req === 1'h1) rq.push_back({rd_mem, rd_addr});
  end
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic run(input logic w, input logic [3:0] id,
    input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
    int t;
    req_write = w;
    req_id = id;
    req_addr = a;
    req_size = s;
    req_wdata = d;
    req_valid = 1'h1;
    t = 0;
    while (req_ready !== 1'h1 && t < 50) begin
      @(negedge sys_clk);
      t++;
    end
    if (t >= 50) error_cnt++;
    @(negedge sys_clk);
    req_valid = 1'h0;
    t = 0;
    while (done !== 1'h1 && t < 60) begin
      @(negedge sys_clk);
      t++;
    end
    if (t >= 60) error_cnt++;
  endtask : run
  task automatic do_row(input int i);
    logic w;
    logic [3:0] s;
    logic [31:0] a;
    logic [31:0] d;
    logic [27:0] ea;
    int n;
    {w, s, a, d} = rows[i];
    wq.delete();
    rq.delete();
    read_data = d[7:0];
    run(w, ID, a, s, d);
    chk("ack_ok", ack_ok, 1);
    if (w) begin
      n = 1 << s;
      chk("bytes", wq.size(), n);
      for (int k = 0; k < n; k++) begin
        ea = a[27:0];
        // array access drops a20-21 and a23-27
        if (a[22]) ea[21:20] = 2'h0;
        if (a[22]) ea[27:23] = 5'h0;
        if (n == 2) ea[0] = k[0];
        if (n == 4) ea[1:0] = k[1:0];
        chk("wr", wq[k], {a[22], ea, d[8*k+:8]});
      end
    end else begin
      chk("rdata", rdata, d[7:0]);
      chk("wire", wb, d[7:0]);
      chk("rd_cnt", rq.size(), 1);
      chk("rd", rq[0], {a[22], 9'h1FF, a[22:0]});
    end
  endtask : do_row
  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    sys_clk = 1'h0;
    reset = 1'h1;
    req_valid = 1'h0;
    req_write = 1'h0;
    req_id = 4'h0;
    req_addr = 32'h0;
    req_size = 4'h0;
    req_wdata = 32'h0;
    read_data = 8'h0;
    rows = '{{1'h1, SIZE_ONE, 32'h0040_0005, 32'h0000_00A5},
      {1'h1, SIZE_TWO, 32'h0012_3457, 32'h0000_C33C},
      {1'h1, SIZE_FOUR, 32'h0FC5_A6B9, 32'h1234_5678},
      {1'h0, SIZE_ONE, 32'h0040_0010, 32'h0000_005A},
      {1'h0, SIZE_ONE, 32'h0030_0000, 32'h0000_00C1},
      {1'h1, SIZE_FOUR, 32'h0040_0007, 32'h8899_AABB}};
    repeat (7) @(negedge sys_clk);
    chk("dev_oe", i_hub_lpc_if.dev_nib_oe, 0);
    reset = 1'h0;
    @(negedge sys_clk);
    for (int i = 0; i < 6; i++) do_row(i);
    // strap mismatch: no byte taken, no ack on the wire
    wq.delete();
    run(1'h1, ID ^ 4'hF, 32'h0040_0000, SIZE_FOUR, 32'h0);
    chk("miss_bytes", wq.size(), 0);
    chk("miss_ack", ack_ok, 0);
    // unknown size code: device drops out before the data
    wq.delete();
    run(1'h1, ID, 32'h0040_0000, 4'h3, 32'h0);
    chk("size_bytes", wq.size(), 0);
    chk("size_ack", ack_ok, 0);
    // reset in mid read, then a clean read must still work
    req_write = 1'h0;
    req_valid = 1'h1;
    repeat (14) @(negedge sys_clk);
    reset = 1'h1;
    req_valid = 1'h0;
    @(negedge sys_clk);
    chk("rst_oe", i_hub_lpc_if.dev_nib_oe, 0);
    chk("rst_frame", i_hub_lpc_if.hub_frame_strobe_n, 1);
    reset = 1'h0;
    @(negedge sys_clk);
    do_row(4);
    report_and_stop();
  end
endmodule : hub_write_lpc_read_cycles_tb
